// ### logic/sysctl_exec.sv
// System-control instruction executor
// Operation
// - Data cache supports fill, flush, invalidate, zero on single 16-byte blocks
// - Block allocate establishes the data cache block holding the effective address
// - Block flush stores the block to memory, then invalidates it
// - Block invalidate drops the data block without any write-back
// - Block writeback stores the addressed data block to memory
// - Load-touch and store-touch both load the addressed block into data cache
// - Block zero clears every byte of the addressed data block
// - Data class invalidate drops the whole selected congruence class
// - Data cache read returns tag or data into the destination register
// - Instruction block invalidate drops the addressed instruction block
// - Instruction block touch loads the addressed block into instruction cache
// - Instruction class invalidate drops classes; both caches offer class invalidation
// - Instruction cache read deposits its result in the debug data register
// - State read copies state register out; state write loads it from source
// - Critical return loads pc from save 2 and state from save 3
// - Ordinary return loads pc from save 0 and state from save 1
// - External enable takes source bit 16, or the immediate bit
// - Invalidate-all clears every entry's valid bit, other fields untouched
// - Entry read: select 0 gives high word and tag id to process id
// - Search writes the hit index to destination; a miss leaves the destination unwritten
// - Translation sync completes at once as a no-op
// - Entry write: select 0 high word plus tag id from process id
`timescale 1ns/100ps
module sysctl_exec (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INSTR_VALID,
    input wire sysctl_pkg::instr_s INSTR,
    output logic INSTR_READY,
    output sysctl_pkg::result_s RESULT,
    output sysctl_pkg::cache_cmd_s DC_CMD,
    input wire logic DC_ACK,
    input wire logic [31:0] DC_RDATA,
    output sysctl_pkg::cache_cmd_s IC_CMD,
    input wire logic IC_ACK,
    input wire logic [31:0] IC_RDATA,
    output logic [31:0] MACHINE_STATE,
    output logic [31:0] PROCESS_ID
);

    // ==================================================================
    // Architected state
    logic [31:0] machine_state_reg;
    logic [31:0] save_restore_0;
    logic [31:0] save_restore_1;
    logic [31:0] save_restore_2;
    logic [31:0] save_restore_3;
    logic [31:0] process_id_register;
    logic [31:0] icache_debug_data_reg;
    logic last_hit;
    logic [31:0] xlate_entry_high [sysctl_pkg::XL_ENTRIES];
    logic [31:0] xlate_entry_low [sysctl_pkg::XL_ENTRIES];
    logic [sysctl_pkg::TAGID_W-1:0] entry_tag_id_field [sysctl_pkg::XL_ENTRIES];

    sysctl_pkg::seq_state_e state;
    sysctl_pkg::seq_state_e next_state;
    sysctl_pkg::instr_s cur;
    logic ready;

    // ==================================================================
    // Instruction acceptance and address formation
    wire logic accept = INSTR_VALID & ready;
    wire sysctl_pkg::instr_op_e op = INSTR.op;
    wire logic [31:0] base = INSTR.first_src_is_r0 ? 32'h0000_0000 : INSTR.first_src_reg;
    wire logic [31:0] eff_addr = base + INSTR.index_src_reg;
    wire logic [31:0] block_addr = {eff_addr[31:sysctl_pkg::BLOCK_OFS_W], 4'h0};
    wire logic [sysctl_pkg::XL_IDX_W-1:0] xl_idx = INSTR.first_src_reg[sysctl_pkg::XL_IDX_W-1:0];

    // Classify the incoming op by the array it needs
    wire logic is_dc = (op == sysctl_pkg::OP_DC_ALLOC) || (op == sysctl_pkg::OP_DC_FLUSH)
        || (op == sysctl_pkg::OP_DC_INVAL) || (op == sysctl_pkg::OP_DC_STORE)
        || (op == sysctl_pkg::OP_DC_TOUCH_LD) || (op == sysctl_pkg::OP_DC_TOUCH_ST)
        || (op == sysctl_pkg::OP_DC_ZERO) || (op == sysctl_pkg::OP_DC_CLASS_INV)
        || (op == sysctl_pkg::OP_DC_READ);
    wire logic is_ic = (op == sysctl_pkg::OP_IC_INVAL) || (op == sysctl_pkg::OP_IC_TOUCH)
        || (op == sysctl_pkg::OP_IC_CLASS_INV) || (op == sysctl_pkg::OP_IC_READ);

    // Data cache command for each op; a flush opens with the store half
    wire sysctl_pkg::cache_op_e dc_op =
        (op == sysctl_pkg::OP_DC_ALLOC) ? sysctl_pkg::CC_ALLOC :
        (op == sysctl_pkg::OP_DC_FLUSH) ? sysctl_pkg::CC_STORE :
        (op == sysctl_pkg::OP_DC_INVAL) ? sysctl_pkg::CC_INVAL :
        (op == sysctl_pkg::OP_DC_STORE) ? sysctl_pkg::CC_STORE :
        (op == sysctl_pkg::OP_DC_ZERO) ? sysctl_pkg::CC_ZERO :
        (op == sysctl_pkg::OP_DC_CLASS_INV) ? sysctl_pkg::CC_CLASS_INV :
        (op == sysctl_pkg::OP_DC_READ) ? sysctl_pkg::CC_READ :
        sysctl_pkg::CC_TOUCH;
    wire sysctl_pkg::cache_op_e ic_op =
        (op == sysctl_pkg::OP_IC_INVAL) ? sysctl_pkg::CC_INVAL :
        (op == sysctl_pkg::OP_IC_TOUCH) ? sysctl_pkg::CC_TOUCH :
        (op == sysctl_pkg::OP_IC_CLASS_INV) ? sysctl_pkg::CC_CLASS_INV :
        sysctl_pkg::CC_READ;
    // Reads need the word address; block and class ops get the block base
    wire logic [31:0] dc_addr = (op == sysctl_pkg::OP_DC_READ) ? eff_addr : block_addr;
    wire logic [31:0] ic_addr = (op == sysctl_pkg::OP_IC_READ) ? eff_addr : block_addr;

    // ==================================================================
    // Translation search, lowest matching valid entry wins
    logic [sysctl_pkg::XL_ENTRIES-1:0] match;
    logic [sysctl_pkg::XL_IDX_W-1:0] hit_idx;
    wire logic hit = |match;

    genvar gi;
    generate
        for (gi = 0; gi < sysctl_pkg::XL_ENTRIES; gi++) begin : g_cmp
            wire logic [21:0] pmask = sysctl_pkg::page_mask(
                xlate_entry_high[gi][sysctl_pkg::XL_SIZE_LSB +: 3]);
            wire logic [21:0] pdiff = xlate_entry_high[gi][31:sysctl_pkg::XL_PAGE_LSB]
                ^ eff_addr[31:sysctl_pkg::XL_PAGE_LSB];
            wire logic tid_ok = (entry_tag_id_field[gi] == 8'h00)
                || (entry_tag_id_field[gi] == process_id_register[sysctl_pkg::TAGID_W-1:0]);
            // Only valid entries take part, so invalidated ones never translate
            assign match[gi] = xlate_entry_high[gi][sysctl_pkg::XL_VALID_POS]
                && ((pdiff & pmask) == 22'h00_0000) && tid_ok;
        end
    endgenerate

    // Priority encoder over the match vector
    always_comb begin
        hit_idx = '0;
        for (int i = sysctl_pkg::XL_ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit_idx = i[sysctl_pkg::XL_IDX_W-1:0];
            end
        end
    end

    // ==================================================================
    // Translation array storage
    generate
        for (gi = 0; gi < sysctl_pkg::XL_ENTRIES; gi++) begin : g_xl
            wire logic sel = accept && (xl_idx == (sysctl_pkg::XL_IDX_W)'(gi))
                && (op == sysctl_pkg::OP_XL_WRITE);
            wire logic inv_all = accept && (op == sysctl_pkg::OP_XL_INV_ALL);
            // Invalidate-all clears only valid bits
            always_ff @(posedge REF_CLK or posedge RST) begin
                if (RST) begin
                    xlate_entry_high[gi] <= 32'h0000_0000;
                    xlate_entry_low[gi] <= 32'h0000_0000;
                    entry_tag_id_field[gi] <= 8'h00;
                end else if (sel && !INSTR.word_select) begin
                    xlate_entry_high[gi] <= INSTR.store_src_reg;
                    entry_tag_id_field[gi] <= process_id_register[sysctl_pkg::TAGID_W-1:0];
                end else if (sel) begin
                    xlate_entry_low[gi] <= INSTR.store_src_reg;
                end else if (inv_all) begin
                    xlate_entry_high[gi][sysctl_pkg::XL_VALID_POS] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==================================================================
    // APB slave: one wait state, registered answer
    wire logic apb_setup = PSEL & PENABLE & ~PREADY;
    wire logic apb_wr = PSEL & PENABLE & PREADY & PWRITE;
    wire logic busy = (state != sysctl_pkg::S_IDLE);
    wire logic ofs_ok = (PADDR <= sysctl_pkg::OFS_STATUS) && (PADDR[1:0] == 2'b00);
    wire logic [31:0] apb_rmux =
        (PADDR == sysctl_pkg::OFS_STATE) ? machine_state_reg :
        (PADDR == sysctl_pkg::OFS_SAVE0) ? save_restore_0 :
        (PADDR == sysctl_pkg::OFS_SAVE1) ? save_restore_1 :
        (PADDR == sysctl_pkg::OFS_SAVE2) ? save_restore_2 :
        (PADDR == sysctl_pkg::OFS_SAVE3) ? save_restore_3 :
        (PADDR == sysctl_pkg::OFS_PROC_ID) ? process_id_register :
        (PADDR == sysctl_pkg::OFS_ICDBG) ? icache_debug_data_reg :
        (PADDR == sysctl_pkg::OFS_STATUS) ? {30'h0000_0000, last_hit, busy} :
        32'h0000_0000;

    // Answer prepared in first access cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= apb_setup;
            PRDATA <= (apb_setup && !PWRITE) ? apb_rmux : 32'h0000_0000;
            PSLVERR <= apb_setup && !ofs_ok;
        end
    end

    // ==================================================================
    // State register updates; the pipeline outranks a same-cycle APB write
    wire logic [31:0] ee_upd = {machine_state_reg[31:sysctl_pkg::EE_POS+1],
        (op == sysctl_pkg::OP_EXT_EN_REG) ? INSTR.store_src_reg[sysctl_pkg::EE_POS] : INSTR.imm_enable,
        machine_state_reg[sysctl_pkg::EE_POS-1:0]};
    wire logic [31:0] next_msr =
        (accept && op == sysctl_pkg::OP_STATE_WR) ? INSTR.store_src_reg :
        (accept && op == sysctl_pkg::OP_RET_CRIT) ? save_restore_3 :
        (accept && op == sysctl_pkg::OP_RET) ? save_restore_1 :
        (accept && (op == sysctl_pkg::OP_EXT_EN_REG || op == sysctl_pkg::OP_EXT_EN_IMM)) ? ee_upd :
        (apb_wr && PADDR == sysctl_pkg::OFS_STATE) ? PWDATA :
        machine_state_reg;
    wire logic xl_rd0 = accept && (op == sysctl_pkg::OP_XL_READ) && !INSTR.word_select;
    wire logic [31:0] next_pid =
        xl_rd0 ? {24'h00_0000, entry_tag_id_field[xl_idx]} :
        (apb_wr && PADDR == sysctl_pkg::OFS_PROC_ID) ? {24'h00_0000, PWDATA[7:0]} :
        process_id_register;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            machine_state_reg <= sysctl_pkg::MSR_RESET;
            process_id_register <= 32'h0000_0000;
        end else begin
            machine_state_reg <= next_msr;
            process_id_register <= next_pid;
        end
    end

    // Save/restore registers are loaded by software only
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            save_restore_0 <= 32'h0000_0000;
            save_restore_1 <= 32'h0000_0000;
            save_restore_2 <= 32'h0000_0000;
            save_restore_3 <= 32'h0000_0000;
        end else if (apb_wr) begin
            if (PADDR == sysctl_pkg::OFS_SAVE0) begin
                save_restore_0 <= PWDATA;
            end else if (PADDR == sysctl_pkg::OFS_SAVE1) begin
                save_restore_1 <= PWDATA;
            end else if (PADDR == sysctl_pkg::OFS_SAVE2) begin
                save_restore_2 <= PWDATA;
            end else if (PADDR == sysctl_pkg::OFS_SAVE3) begin
                save_restore_3 <= PWDATA;
            end
        end
    end

    assign MACHINE_STATE = machine_state_reg;
    assign PROCESS_ID = process_id_register;

    // ==================================================================
    // Sequencer for ops that need a cache array
    wire logic cur_flush = (cur.op == sysctl_pkg::OP_DC_FLUSH);
    always_comb begin
        next_state = state;
        case (state)
            sysctl_pkg::S_IDLE: begin
                if (accept && is_dc) begin
                    next_state = sysctl_pkg::S_DREQ;
                end else if (accept && is_ic) begin
                    next_state = sysctl_pkg::S_IREQ;
                end
            end
            sysctl_pkg::S_DREQ: begin
                if (DC_ACK) begin
                    next_state = cur_flush ? sysctl_pkg::S_DINV : sysctl_pkg::S_IDLE;
                end
            end
            sysctl_pkg::S_DINV: begin
                if (DC_ACK) begin
                    next_state = sysctl_pkg::S_IDLE;
                end
            end
            sysctl_pkg::S_IREQ: begin
                if (IC_ACK) begin
                    next_state = sysctl_pkg::S_IDLE;
                end
            end
            default: next_state = sysctl_pkg::S_IDLE;
        endcase
    end

    wire logic dc_done = DC_ACK && ((state == sysctl_pkg::S_DINV)
        || (state == sysctl_pkg::S_DREQ && !cur_flush));
    wire logic ic_done = IC_ACK && (state == sysctl_pkg::S_IREQ);

    // Ready is registered, so single-cycle ops may follow back to back
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= sysctl_pkg::S_IDLE;
            ready <= 1'b0;
            cur <= '0;
        end else begin
            state <= next_state;
            ready <= (next_state == sysctl_pkg::S_IDLE);
            if (accept) begin
                cur <= INSTR;
            end
        end
    end
    assign INSTR_READY = ready;

    // Cache commands: valid holds until acknowledged
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            DC_CMD <= '0;
            IC_CMD <= '0;
        end else begin
            if (accept && is_dc) begin
                DC_CMD <= '{valid: 1'b1, op: dc_op, addr: dc_addr};
            end else if (DC_ACK && state == sysctl_pkg::S_DREQ && cur_flush) begin
                DC_CMD.op <= sysctl_pkg::CC_INVAL;
            end else if (DC_ACK) begin
                DC_CMD.valid <= 1'b0;
            end
            if (accept && is_ic) begin
                IC_CMD <= '{valid: 1'b1, op: ic_op, addr: ic_addr};
            end else if (IC_ACK) begin
                IC_CMD.valid <= 1'b0;
            end
        end
    end

    // Instruction cache read lands here only
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            icache_debug_data_reg <= 32'h0000_0000;
        end else if (ic_done && cur.op == sysctl_pkg::OP_IC_READ) begin
            icache_debug_data_reg <= IC_RDATA;
        end
    end

    // ==================================================================
    // Result word; on a search miss the destination is not written
    wire logic [31:0] xl_rd_word = INSTR.word_select ? xlate_entry_low[xl_idx] : xlate_entry_high[xl_idx];
    wire logic imm_gpr = (op == sysctl_pkg::OP_STATE_RD) || (op == sysctl_pkg::OP_XL_READ)
        || (op == sysctl_pkg::OP_XL_SEARCH && hit);
    wire logic [31:0] imm_data =
        (op == sysctl_pkg::OP_STATE_RD) ? machine_state_reg :
        (op == sysctl_pkg::OP_XL_READ) ? xl_rd_word :
        (op == sysctl_pkg::OP_XL_SEARCH && hit) ? {26'h000_0000, hit_idx} :
        32'h0000_0000;
    wire logic is_ret = (op == sysctl_pkg::OP_RET_CRIT) || (op == sysctl_pkg::OP_RET);
    wire logic [31:0] ret_pc = (op == sysctl_pkg::OP_RET_CRIT) ? save_restore_2 : save_restore_0;
    wire logic rec_search = (op == sysctl_pkg::OP_XL_SEARCH) && INSTR.record;

    // Pipeline-only ops, sync included, finish at once
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RESULT <= '0;
            last_hit <= 1'b0;
        end else if (accept && !is_dc && !is_ic) begin
            RESULT <= '{valid: 1'b1, gpr_we: imm_gpr, gpr_data: imm_data,
                cr_eq_we: rec_search, zero_result_flag: rec_search && hit,
                pc_load: is_ret, pc_target: is_ret ? ret_pc : 32'h0000_0000};
            if (op == sysctl_pkg::OP_XL_SEARCH) begin
                last_hit <= hit;
            end
        end else if (dc_done) begin
            RESULT <= '{valid: 1'b1, gpr_we: cur.op == sysctl_pkg::OP_DC_READ,
                gpr_data: (cur.op == sysctl_pkg::OP_DC_READ) ? DC_RDATA : 32'h0000_0000,
                cr_eq_we: 1'b0, zero_result_flag: 1'b0, pc_load: 1'b0, pc_target: 32'h0000_0000};
        end else if (ic_done) begin
            RESULT <= '{valid: 1'b1, gpr_we: 1'b0, gpr_data: 32'h0000_0000,
                cr_eq_we: 1'b0, zero_result_flag: 1'b0, pc_load: 1'b0, pc_target: 32'h0000_0000};
        end else begin
            RESULT <= '0;
        end
    end

endmodule : sysctl_exec

// ### logic/sysctl_pkg.sv
// Shared types and constants for the system-control instruction executor
package sysctl_pkg;

    // ==================================================================
    // Sizes and field positions (bit 0 is the least significant bit)
    localparam int XL_ENTRIES = 64;
    localparam int XL_IDX_W = 6;
    localparam int BLOCK_OFS_W = 4;          // 16-byte cache block
    localparam int EE_POS = 15;              // Architected bit 16, counted from the top
    localparam int TAGID_W = 8;              // Process id bits 24:31, counted from the top
    localparam int XL_VALID_POS = 6;
    localparam int XL_SIZE_LSB = 7;
    localparam int XL_PAGE_LSB = 10;
    localparam logic [31:0] MSR_RESET = 32'h0000_0000;

    // ==================================================================
    // Register offsets on the APB port
    localparam logic [7:0] OFS_STATE = 8'h00;
    localparam logic [7:0] OFS_SAVE0 = 8'h04;
    localparam logic [7:0] OFS_SAVE1 = 8'h08;
    localparam logic [7:0] OFS_SAVE2 = 8'h0c;
    localparam logic [7:0] OFS_SAVE3 = 8'h10;
    localparam logic [7:0] OFS_PROC_ID = 8'h14;
    localparam logic [7:0] OFS_ICDBG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // ==================================================================
    // Instruction codes from the decoder
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_DC_ALLOC = 5'h01, OP_DC_FLUSH = 5'h02, OP_DC_INVAL = 5'h03,
        OP_DC_STORE = 5'h04, OP_DC_TOUCH_LD = 5'h05, OP_DC_TOUCH_ST = 5'h06, OP_DC_ZERO = 5'h07,
        OP_DC_CLASS_INV = 5'h08, OP_DC_READ = 5'h09, OP_IC_INVAL = 5'h0a, OP_IC_TOUCH = 5'h0b,
        OP_IC_CLASS_INV = 5'h0c, OP_IC_READ = 5'h0d, OP_STATE_RD = 5'h0e, OP_STATE_WR = 5'h0f,
        OP_RET_CRIT = 5'h10, OP_RET = 5'h11, OP_EXT_EN_REG = 5'h12, OP_EXT_EN_IMM = 5'h13,
        OP_XL_INV_ALL = 5'h14, OP_XL_READ = 5'h15, OP_XL_SEARCH = 5'h16, OP_XL_SYNC = 5'h17,
        OP_XL_WRITE = 5'h18
    } instr_op_e;

    // Commands to a cache array
    typedef enum logic [2:0] {
        CC_ALLOC = 3'h0, CC_STORE = 3'h1, CC_INVAL = 3'h2, CC_TOUCH = 3'h3,
        CC_ZERO = 3'h4, CC_CLASS_INV = 3'h5, CC_READ = 3'h6
    } cache_op_e;

    // Executor sequencer, Gray coded along issue, second issue
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_DREQ = 2'b01, S_DINV = 2'b11, S_IREQ = 2'b10
    } seq_state_e;

    typedef struct packed {
        instr_op_e op;
        logic first_src_is_r0;
        logic record;
        logic word_select;
        logic imm_enable;
        logic [31:0] first_src_reg;
        logic [31:0] index_src_reg;
        logic [31:0] store_src_reg;
    } instr_s;

    typedef struct packed {
        logic valid;
        cache_op_e op;
        logic [31:0] addr;
    } cache_cmd_s;

    typedef struct packed {
        logic valid;
        logic gpr_we;
        logic [31:0] gpr_data;
        logic cr_eq_we;
        logic zero_result_flag;
        logic pc_load;
        logic [31:0] pc_target;
    } result_s;

    // Page mask for a size code (1 KB times 4 to the n)
    function automatic logic [21:0] page_mask(input logic [2:0] size);
        logic [21:0] lowbits;
        lowbits = (22'h00_0001 << {size, 1'b0}) - 22'h00_0001;
        page_mask = ~lowbits;
    endfunction : page_mask

endpackage : sysctl_pkg

// ### verif/cache_model.sv
// Behavioural cache array answering block and class commands
`timescale 1ns/100ps
module cache_model #(parameter int DLY = 1) (
    input wire logic clk,
    input wire logic rst,
    input wire sysctl_pkg::cache_cmd_s cmd,
    output logic ack,
    output logic [31:0] rdata
);
    // ==========================================================
    // Acknowledge DLY+1 cycles after the command appears, data churns otherwise
    int cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            ack <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ack <= cmd.valid && !ack && cnt >= DLY;
            cnt <= (cmd.valid && !ack) ? cnt + 1 : 0;
            rdata <= (cmd.valid && !ack && cnt >= DLY) ? ~cmd.addr : rdata + 32'h1;
        end
    end
endmodule : cache_model

// ### verif/sysctl_exec_chk.sv
// Port checker for the system-control executor
`timescale 1ns/100ps
module sysctl_exec_chk (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PREADY,
    input wire logic INSTR_VALID,
    input wire sysctl_pkg::instr_s INSTR,
    input wire logic INSTR_READY,
    input wire sysctl_pkg::result_s RESULT,
    input wire sysctl_pkg::cache_cmd_s DC_CMD,
    input wire logic DC_ACK,
    input wire logic [31:0] MACHINE_STATE
);
    // ==========================================================
    // Taken instruction and its address
    wire go = INSTR_VALID && INSTR_READY;
    wire [4:0] op = INSTR.op;
    wire [31:0] ea = (INSTR.first_src_is_r0 ? 32'h0 : INSTR.first_src_reg) + INSTR.index_src_reg;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    state_read_a: assert property (go && op == sysctl_pkg::OP_STATE_RD |=>
        RESULT.valid && RESULT.gpr_we && RESULT.gpr_data == $past(MACHINE_STATE)) else $error("state read");
    state_write_a: assert property (go && op == sysctl_pkg::OP_STATE_WR |=>
        MACHINE_STATE == $past(INSTR.store_src_reg)) else $error("state write");
    ext_imm_a: assert property (go && op == sysctl_pkg::OP_EXT_EN_IMM |=>
        MACHINE_STATE[sysctl_pkg::EE_POS] == $past(INSTR.imm_enable)) else $error("enable bit");
    flush_store_a: assert property (go && op == sysctl_pkg::OP_DC_FLUSH |=>
        DC_CMD.valid && DC_CMD.op == sysctl_pkg::CC_STORE && DC_CMD.addr == ($past(ea) & 32'hffff_fff0))
        else $error("flush store");
    zero_block_a: assert property (go && op == sysctl_pkg::OP_DC_ZERO |=>
        DC_CMD.valid && DC_CMD.op == sysctl_pkg::CC_ZERO) else $error("zero block");
    cmd_hold_a: assert property (DC_CMD.valid && !DC_ACK |=> $stable(DC_CMD)) else $error("cmd dropped");
    inval_done_a: assert property (DC_ACK && DC_CMD.op == sysctl_pkg::CC_INVAL |=>
        RESULT.valid && !DC_CMD.valid) else $error("inval done");
    busy_refuse_a: assert property (DC_CMD.valid |-> !INSTR_READY) else $error("ready while busy");
    // Main scenarios
    cover property (go && op == sysctl_pkg::OP_DC_FLUSH);
    cover property (DC_ACK && DC_CMD.op == sysctl_pkg::CC_INVAL);
    cover property (PREADY && PSEL);
endmodule : sysctl_exec_chk
bind sysctl_exec sysctl_exec_chk chk (.REF_CLK, .RST, .PSEL, .PREADY, .INSTR_VALID, .INSTR, .INSTR_READY,
    .RESULT, .DC_CMD, .DC_ACK, .MACHINE_STATE);

// ### verif/system_control_instr_exec_tb.sv
// Self-checking bench for the system-control executor
`timescale 1ns/100ps
module system_control_instr_exec_tb;
    logic REF_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, INSTR_VALID = 0, e;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, MACHINE_STATE, PROCESS_ID, DC_RDATA, IC_RDATA, q;
    logic PREADY, PSLVERR, INSTR_READY, DC_ACK, IC_ACK;
    sysctl_pkg::instr_s INSTR = '0;
    sysctl_pkg::result_s RESULT, r;
    sysctl_pkg::cache_cmd_s DC_CMD, IC_CMD;
    int failures = 0, cmp_count = 0;
    always #20 REF_CLK = ~REF_CLK;
    sysctl_exec dut (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .INSTR_VALID, .INSTR, .INSTR_READY, .RESULT, .DC_CMD, .DC_ACK, .DC_RDATA, .IC_CMD, .IC_ACK, .IC_RDATA,
        .MACHINE_STATE, .PROCESS_ID);
    // Slow data array, prompt instruction array
    cache_model #(.DLY(3)) dcm (.clk(REF_CLK), .rst(RST), .cmd(DC_CMD), .ack(DC_ACK), .rdata(DC_RDATA));
    cache_model #(.DLY(0)) icm (.clk(REF_CLK), .rst(RST), .cmd(IC_CMD), .ack(IC_ACK), .rdata(IC_RDATA));
    // ==========================================================
    // Bus and instruction drivers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK iff PREADY === 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask : apb
    task automatic exec(input sysctl_pkg::instr_op_e op, input logic [31:0] a, b, s, input logic ws);
        INSTR <= '{op, 1'b0, 1'b1, ws, ws, a, b, s};
        INSTR_VALID <= 1'b1;
        @(posedge REF_CLK iff INSTR_READY === 1'b1);
        INSTR_VALID <= 1'b0;
        @(posedge REF_CLK iff RESULT.valid === 1'b1);
        r = RESULT;
    endtask : exec
    // ==========================================================
    // Scenarios
    task automatic t_state;
        for (int i = 1; i < 5; i++) apb(1'b1, 8'(4 * i), 32'h1111_1111 * i);
        exec(sysctl_pkg::OP_RET_CRIT, 0, 0, 0, 0);
        chk({r.pc_target[15:0], MACHINE_STATE[15:0]}, 32'h3333_4444, "crit return");
        exec(sysctl_pkg::OP_RET, 0, 0, 0, 0);
        chk({r.pc_target[15:0], MACHINE_STATE[15:0]}, 32'h1111_2222, "return");
        exec(sysctl_pkg::OP_STATE_WR, 0, 0, 32'h0f0f_0000, 0);
        exec(sysctl_pkg::OP_EXT_EN_REG, 0, 0, 32'h0000_8000, 0);
        exec(sysctl_pkg::OP_STATE_RD, 0, 0, 0, 0);
        chk(r.gpr_data, 32'h0f0f_8000, "state read");
        exec(sysctl_pkg::OP_EXT_EN_IMM, 0, 0, 0, 0);
        chk(MACHINE_STATE, 32'h0f0f_0000, "enable clear");
        apb(1'b0, 8'h40, 0);
        chk({31'h0, e}, 32'h1, "unmapped");
    endtask : t_state
    task automatic t_cache;
        // Maintenance codes, no register write
        for (int k = 1; k < 13; k++) if (k != 9) begin
            exec(sysctl_pkg::instr_op_e'(k), 32'h0000_1003, 32'h0000_0020, 0, 0);
            chk({31'h0, r.gpr_we}, 32'h0, "maintenance");
        end
        exec(sysctl_pkg::OP_DC_READ, 32'h0000_1003, 32'h0000_0020, 0, 0);
        chk(r.gpr_data, ~32'h0000_1023, "data read");
        exec(sysctl_pkg::OP_IC_READ, 32'h0000_2001, 32'h0000_0010, 0, 0);
        apb(1'b0, sysctl_pkg::OFS_ICDBG, 0);
        chk(q, ~32'h0000_2011, "icache read");
    endtask : t_cache
    task automatic t_xlate;
        apb(1'b1, sysctl_pkg::OFS_PROC_ID, 32'h0000_00a5);
        exec(sysctl_pkg::OP_XL_WRITE, 5, 0, 32'h0001_0440, 0);
        exec(sysctl_pkg::OP_XL_WRITE, 5, 0, 32'hdead_beef, 1);
        apb(1'b1, sysctl_pkg::OFS_PROC_ID, 0);
        exec(sysctl_pkg::OP_XL_READ, 5, 0, 0, 1);
        chk(r.gpr_data, 32'hdead_beef, "low word");
        exec(sysctl_pkg::OP_XL_READ, 5, 0, 0, 0);
        chk({r.gpr_data[23:0], PROCESS_ID[7:0]}, 32'h0104_40a5, "high word");
        exec(sysctl_pkg::OP_XL_SEARCH, 32'h0001_0500, 32'h0000_0023, 0, 0);
        chk({r.gpr_data[30:0], r.zero_result_flag}, 32'h0000_000b, "hit");
        exec(sysctl_pkg::OP_XL_INV_ALL, 0, 0, 0, 0);
        exec(sysctl_pkg::OP_XL_SEARCH, 32'h0001_0500, 32'h0000_0023, 0, 0);
        chk({r.gpr_we, r.zero_result_flag}, 32'h0, "miss");
        exec(sysctl_pkg::OP_XL_READ, 5, 0, 0, 0);
        chk(r.gpr_data, 32'h0001_0400, "valid cleared");
        exec(sysctl_pkg::OP_XL_SYNC, 0, 0, 0, 0);
        chk({31'h0, r.gpr_we}, 32'h0, "sync");
    endtask : t_xlate
    task automatic finish_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // Reset, then scenarios
    initial begin
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        t_state();
        t_cache();
        t_xlate();
        finish_test();
    end
    // Watchdog, far past the test length
    initial begin
        #100000;
        failures++;
        finish_test();
    end
endmodule : system_control_instr_exec_tb
